// [rtl/adcr_pkg.sv]
package adcr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int RES_W  = 16;               // Result word width
  localparam int BYTE_W = 8;                // Parallel port width
  localparam int CNT_W  = 10;               // Conversion timer width
  localparam int BIT_W  = 5;                // Serial bit counter width

  // ----------------------------------------------------------------
  // Clock and timing figures
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 50_000_000;
  localparam int CLK_NS       = 1_000_000_000 / CLK_HZ;
  localparam int PREV_HOLD_NS = 12_000;     // Previous data held, least
  localparam int DATA_MAX_NS  = 20_000;     // New data valid, longest
  localparam int UPDATE_NS    = 18_000;     // Chosen output update moment
  localparam int BUSY_GAP_NS  = 60;         // Data valid to busy high
  localparam int START_DLY_NS = 2_400;      // Start to first data clock
  localparam int DCLK_HALF_NS = 410;        // Half period, internal clock

  // Longest time rounds down, least time rounds up
  localparam int UPDATE_CYC   = UPDATE_NS / CLK_NS;
  localparam int PREV_CYC     = (PREV_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int DATA_MAX_CYC = DATA_MAX_NS / CLK_NS;
  localparam int BUSY_GAP_CYC = (BUSY_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int START_CYC    = START_DLY_NS / CLK_NS;
  localparam int HALF_CYC     = DCLK_HALF_NS / CLK_NS;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [RES_W-1:0] RES_RST = 16'h0000;
  localparam logic             SDO_RST = 1'h0;

  // ----------------------------------------------------------------
  // Conversion sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ADCR_IDLE = 3'b001,
    ADCR_CONV = 3'b010,
    ADCR_GAP  = 3'b100
  } adcr_state_t;

endpackage

// [rtl/adcr_ser_if.sv]
`timescale 1ns/100ps
// Result word handed from the core domain to the external-clock shifter
interface adcr_ser_if;
  import adcr_pkg::*;
  logic             load_tgl;              // Toggles on each new result
  logic [RES_W-1:0] word;                  // Changes in the same cycle as toggle
  logic             bit_out;               // Current shifter output bit
  modport src  (output load_tgl, output word, input bit_out);
  modport link (input load_tgl, input word, output bit_out);
endinterface

// [rtl/adcr_ser_link.sv]
`timescale 1ns/100ps
// Shifter clocked by the host's data clock
module adcr_ser_link
  import adcr_pkg::*;
(
  // Link clock and reset
  input  wire logic   link_clk,
  input  wire logic   rst_n,
  // Raw control pins
  input  wire logic   cs_n,
  input  wire logic   rd_conv,
  // Core side
  adcr_ser_if.link    ser
);

  logic [2:0]       tgl_sync;
  logic [1:0]       rst_sync;
  logic [1:0]       cs_sync;
  logic [1:0]       rc_sync;
  logic [RES_W-1:0] shreg;

  // ----------------------------------------------------------------
  // Synchronisers into the link domain
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    rst_sync <= {rst_sync[0], rst_n};
    cs_sync  <= {cs_sync[0], cs_n};
    rc_sync  <= {rc_sync[0], rd_conv};
  end

  // Toggle crossing; tgl_sync[2] only remembers the last seen level
  always_ff @(posedge link_clk) begin
    if (!rst_sync[1]) begin
      tgl_sync <= 3'h0;
    end else begin
      tgl_sync <= {tgl_sync[1:0], ser.load_tgl};
    end
  end

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  // A fresh result wins over a shift; the clock may stop between
  // frames, so a load waits for the host's third edge after the toggle
  always_ff @(posedge link_clk) begin
    if (!rst_sync[1]) begin
      shreg <= RES_RST;
    end else if (tgl_sync[2] != tgl_sync[1]) begin
      shreg <= ser.word;
    end else if (!cs_sync[1] && rc_sync[1]) begin
      shreg <= {shreg[RES_W-2:0], 1'h0};
    end
  end

  assign ser.bit_out = shreg[RES_W-1];

endmodule // adcr_ser_link

// [rtl/adcr_top.sv]
`timescale 1ns/100ps
// Summary of operation
// - Previous result stays on outputs at least 12 us after conversion start.
// - Parallel pins driven whenever chip select low and read/convert high.
// - Serial data output is always driven, never high impedance.
// - Serial shift clock comes from device or host per clock source select.
// - New result valid on parallel pins within 20 us of conversion start; serial pin waits for host edges or the next start.
// - Output register updated first; busy rises 60 ns later, 40 ns after the parallel pins.
// - Start on read/convert fall with select low, or select fall with it low.
// - Convert commands ignored while busy is low.
// - Byte select low gives upper byte, high gives lower byte.
module adcr_top
  import adcr_pkg::*;
(
  // Core clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Host control pins
  input  wire logic              cs_n,
  input  wire logic              rd_conv,
  input  wire logic              byte_sel,
  input  wire logic              clock_source_select,
  // Converter core result
  input  wire logic [RES_W-1:0]  conv_sample,
  // Busy indication, low during conversion
  output logic                   busy_n,
  // Parallel result pins
  output logic [BYTE_W-1:0]      parallel_result_bus_out,
  output logic                   parallel_result_bus_oe_n,
  // Serial result pins
  output logic                   serial_result_out,
  input  wire logic              serial_shift_clock_in,
  output logic                   serial_shift_clock_out,
  output logic                   serial_shift_clock_oe_n
);

  adcr_ser_if       ser ();
  adcr_state_t      state;
  logic [CNT_W-1:0] cnt;
  logic [RES_W-1:0] out_word;
  logic             load_tgl;
  logic             cs_s1, cs_s2, cs_d;
  logic             rc_s1, rc_s2, rc_d;
  logic             bs_s1, bs_s2;
  logic             src_s1, src_s2;
  logic             start;
  logic             int_act;
  logic [CNT_W-1:0] int_cnt;
  logic [BIT_W-1:0] int_bits;
  logic [RES_W-1:0] int_shreg;

  // Constants sized to the counter they meet
  localparam logic [CNT_W-1:0] UPD_LAST  = CNT_W'(UPDATE_CYC - 1);
  localparam logic [CNT_W-1:0] GAP_LAST  = CNT_W'(BUSY_GAP_CYC - 1);
  localparam logic [CNT_W-1:0] STRT_LAST = CNT_W'(START_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
  localparam logic [BIT_W-1:0] BITS_ALL  = BIT_W'(RES_W);

  // Last cycle before the update; sequencer and output register share it
  function automatic logic upd_hit(input adcr_state_t      st,
                                   input logic [CNT_W-1:0] c);
    return (st == ADCR_CONV) && (c == UPD_LAST);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Idle pin levels are deselected, so no false start after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_s1  <= 1'h1;
      cs_s2  <= 1'h1;
      cs_d   <= 1'h1;
      rc_s1  <= 1'h1;
      rc_s2  <= 1'h1;
      rc_d   <= 1'h1;
      bs_s1  <= 1'h0;
      bs_s2  <= 1'h0;
      src_s1 <= 1'h1;
      src_s2 <= 1'h1;
    end else begin
      cs_s1  <= cs_n;
      cs_s2  <= cs_s1;
      cs_d   <= cs_s2;
      rc_s1  <= rd_conv;
      rc_s2  <= rc_s1;
      rc_d   <= rc_s2;
      bs_s1  <= byte_sel;
      bs_s2  <= bs_s1;
      src_s1 <= clock_source_select;
      src_s2 <= src_s1;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // Either falling edge counts; only honoured while idle
  assign start = (state == ADCR_IDLE) &&
                 ((cs_d && !cs_s2 && !rc_s2) ||
                  (rc_d && !rc_s2 && !cs_s2));

  // Update falls between the 12 us hold and the 20 us limit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state  <= ADCR_IDLE;
      cnt    <= '0;
      busy_n <= 1'h1;
    end else begin
      unique case (state)
        ADCR_IDLE: begin
          cnt <= '0;
          if (start) begin
            state  <= ADCR_CONV;
            busy_n <= 1'h0;
          end
        end
        ADCR_CONV: begin
          if (upd_hit(state, cnt)) begin
            state <= ADCR_GAP;
            cnt   <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ADCR_GAP: begin
          if (cnt == GAP_LAST) begin
            state  <= ADCR_IDLE;
            busy_n <= 1'h1;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      endcase
    end
  end

  // Output register takes the result at the 18 us update moment
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_word <= RES_RST;
      load_tgl <= 1'h0;
    end else if (upd_hit(state, cnt)) begin
      out_word <= conv_sample;
      load_tgl <= ~load_tgl;
    end
  end

  // ----------------------------------------------------------------
  // Parallel port
  // ----------------------------------------------------------------
  // Driven on chip select low and read high, also in serial use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      parallel_result_bus_oe_n <= 1'h1;
      parallel_result_bus_out  <= '0;
    end else begin
      parallel_result_bus_oe_n <= !(!cs_s2 && rc_s2);
      parallel_result_bus_out  <= bs_s2 ? out_word[BYTE_W-1:0]
                                        : out_word[RES_W-1:BYTE_W];
    end
  end

  // ----------------------------------------------------------------
  // Internal data clock
  // ----------------------------------------------------------------
  // Sends the previous result after each start; the update comes
  // well after the 16th pulse, so the word is stable while sending
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_act                <= 1'h0;
      int_cnt                <= '0;
      int_bits               <= '0;
      int_shreg              <= RES_RST;
      serial_shift_clock_out <= 1'h0;
    end else if (start && !src_s2) begin
      int_act                <= 1'h1;
      int_cnt                <= STRT_LAST;
      int_bits               <= '0;
      int_shreg              <= out_word;
      serial_shift_clock_out <= 1'h0;
    end else if (int_act) begin
      if (int_cnt != '0) begin
        int_cnt <= int_cnt - 1'b1;
      end else if (!serial_shift_clock_out) begin
        serial_shift_clock_out <= 1'h1;
        int_cnt                <= HALF_LAST;
      end else begin
        // Falling edge moves to the next bit
        serial_shift_clock_out <= 1'h0;
        int_cnt                <= HALF_LAST;
        int_shreg              <= {int_shreg[RES_W-2:0], 1'h0};
        int_bits               <= int_bits + 1'b1;
        if (int_bits == BITS_ALL - 1'b1) begin
          int_act <= 1'h0;
        end
      end
    end
  end

  // Clock pin is driven only when the device owns it
  assign serial_shift_clock_oe_n = src_s2;

  // ----------------------------------------------------------------
  // External data clock shifter
  // ----------------------------------------------------------------
  assign ser.load_tgl = load_tgl;
  assign ser.word     = out_word;

  adcr_ser_link u_link (
    .link_clk (serial_shift_clock_in),
    .rst_n    (rst_n),
    .cs_n     (cs_n),
    .rd_conv  (rd_conv),
    .ser      (ser.link)
  );

  // Serial pin always driven; source is static during operation
  assign serial_result_out = src_s2 ? ser.bit_out
                                    : int_shreg[RES_W-1];

endmodule // adcr_top

// [verif/adcr_chk.sv]
`timescale 1ns/100ps
// Port checks on conversion timing and the output enables
module adcr_chk
  import adcr_pkg::*;
(
  // Clock, reset and host pins
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              cs_n,
  input  wire logic              rd_conv,
  input  wire logic              byte_sel,
  input  wire logic              clock_source_select,
  // Device outputs
  input  wire logic              busy_n,
  input  wire logic [BYTE_W-1:0] parallel_result_bus_out,
  input  wire logic              parallel_result_bus_oe_n,
  input  wire logic              serial_shift_clock_out,
  input  wire logic              serial_shift_clock_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  localparam int LOW_CYC = UPDATE_CYC + BUSY_GAP_CYC;
  logic [10:0] low_cnt;
  // Busy-low length; a restart inside a conversion would overrun it
  always_ff @(posedge clk) begin
    low_cnt <= (!rst_n || busy_n) ? 11'h000 : low_cnt + 11'h001;
  end
  property p_oe_on;  (!cs_n && rd_conv)[*4] |-> !parallel_result_bus_oe_n;
  endproperty
  property p_oe_off; (cs_n || !rd_conv)[*4] |-> parallel_result_bus_oe_n;
  endproperty
  property p_start_rc; busy_n && !cs_n && $fell(rd_conv) |-> ##[2:5] !busy_n;
  endproperty
  property p_start_cs; busy_n && !rd_conv && $fell(cs_n) |-> ##[2:5] !busy_n;
  endproperty
  property p_busy_len; $rose(busy_n) |-> low_cnt == 11'(LOW_CYC);
  endproperty
  property p_busy_max; low_cnt <= 11'(LOW_CYC);
  endproperty
  // Previous word must not move early in the conversion; the byte pin
  // reaches the data three cycles late, so compare its older samples
  property p_hold;
    !busy_n && low_cnt > 11'h004 && low_cnt < 11'(PREV_CYC) &&
      $past(byte_sel, 3) == $past(byte_sel, 4)
      |-> $stable(parallel_result_bus_out);
  endproperty
  property p_clk_oe;
    $stable(clock_source_select)[*8]
      |-> serial_shift_clock_oe_n == clock_source_select;
  endproperty
  property p_clk_idle; busy_n[*8] |-> !serial_shift_clock_out;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe_n high");
  a_oe_off: assert property (p_oe_off) else $error("oe_n low");
  a_start_rc: assert property (p_start_rc) else $error("no start");
  a_start_cs: assert property (p_start_cs) else $error("no start");
  a_busy_len: assert property (p_busy_len) else $error("busy len");
  a_busy_max: assert property (p_busy_max) else $error("busy long");
  a_hold: assert property (p_hold) else $error("prev lost");
  a_clk_oe: assert property (p_clk_oe) else $error("clk oe_n");
  a_clk_idle: assert property (p_clk_idle) else $error("clk runs");
  c_busy: cover property ($rose(busy_n));
  c_read: cover property (!parallel_result_bus_oe_n);
  c_dclk: cover property ($rose(serial_shift_clock_out));
endmodule // adcr_chk

bind adcr_top adcr_chk u_chk (.clk, .rst_n, .cs_n, .rd_conv, .byte_sel,
  .clock_source_select, .busy_n, .parallel_result_bus_out,
  .parallel_result_bus_oe_n, .serial_shift_clock_out,
  .serial_shift_clock_oe_n);

// [verif/adcr_host.sv]
`timescale 1ns/100ps
// Host: external data clock and capture of the internal-clock stream
module adcr_host
  import adcr_pkg::*;
(
  // Core clock and device serial pins
  input  wire logic             clk,
  input  wire logic             sclk_dev,
  input  wire logic             sdo,
  // Host data clock and captured word
  output logic                  link_clk,
  output logic [RES_W-1:0]      cap
);
  logic sclk_q;
  initial link_clk = 1'b0;
  // Bursts only; the clock stays low between them, phase offset on purpose
  task automatic pulses(input int n);
    #3.3;
    repeat (n) begin
      #7.5 link_clk = 1'b1;
      #7.5 link_clk = 1'b0;
    end
  endtask
  // Bits are steady at the rising edge of the device clock, MSB first
  always @(posedge clk) begin
    sclk_q <= sclk_dev;
    if (sclk_dev && !sclk_q) cap <= {cap[RES_W-2:0], sdo};
  end
endmodule // adcr_host

// [verif/tb_top.sv]
`timescale 1ns/100ps
module tb_top
  import adcr_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              cs_n = 1'b1;
  logic              rd_conv = 1'b1;
  logic              byte_sel = 1'b0;
  logic              clock_source_select = 1'b0;
  logic [RES_W-1:0]  conv_sample = 16'h0000;
  logic [RES_W-1:0]  prev = 16'h0000;
  logic [RES_W-1:0]  cap;
  logic [BYTE_W-1:0] parallel_result_bus_out;
  logic              busy_n, parallel_result_bus_oe_n, serial_result_out;
  logic              serial_shift_clock_in, serial_shift_clock_out;
  logic              serial_shift_clock_oe_n;
  int                n_errors = 0;
  int                compares = 0;
  always #10 clk = ~clk;
  adcr_top u_dut (.clk, .rst_n, .cs_n, .rd_conv, .byte_sel,
    .clock_source_select, .conv_sample, .busy_n, .parallel_result_bus_out,
    .parallel_result_bus_oe_n, .serial_result_out, .serial_shift_clock_in,
    .serial_shift_clock_out, .serial_shift_clock_oe_n);
  adcr_host u_host (.clk, .sclk_dev(serial_shift_clock_out),
    .sdo(serial_result_out), .link_clk(serial_shift_clock_in), .cap);
  // Inputs always move 2 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string what, input logic [RES_W-1:0] e, g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Bounded wait for the end of a conversion
  task automatic wait_idle();
    for (int i = 0; i < 1200 && busy_n !== 1'b1; i++) cyc(1);
    if (busy_n !== 1'b1) begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic rd(input logic bs, input logic [BYTE_W-1:0] e);
    cs_n = 1'b0;
    rd_conv = 1'b1;
    byte_sel = bs;
    cyc(5);
    chk("oe_n", 16'h0000, {15'h0000, parallel_result_bus_oe_n});
    chk("byte", {8'h00, e}, {8'h00, parallel_result_bus_out});
  endtask
  // Start by either pin edge, read early, then send an ignored command
  task automatic convert(input logic [RES_W-1:0] s, input bit by_cs);
    conv_sample = s;
    byte_sel = 1'b0;
    // Other pin low, starting pin high, so only the chosen edge starts
    cs_n = by_cs;
    rd_conv = !by_cs;
    cyc(4);
    if (by_cs) cs_n = 1'b0;
    else rd_conv = 1'b0;
    cyc(8);
    chk("busy_n", 16'h0000, {15'h0000, busy_n});
    rd(1'b0, prev[15:8]);
    rd(1'b1, prev[7:0]);
    rd_conv = 1'b0;
    cyc(4);
    rd_conv = 1'b1;
    cs_n = 1'b1;
    wait_idle();
    prev = s;
  endtask
  initial begin
    fork
      u_host.pulses(4);
      cyc(12);
    join
    rst_n = 1'b1;
    cyc(4);
    chk("oe_n", 16'h0001, {15'h0000, parallel_result_bus_oe_n});
    convert(16'hA5C3, 1'b0);
    rd(1'b0, 8'hA5);
    rd(1'b1, 8'hC3);
    chk("serial", 16'h0000, cap);
    convert(16'h3C96, 1'b1);
    chk("serial", 16'hA5C3, cap);
    rd(1'b1, 8'h96);
    rd(1'b0, 8'h3C);
    cs_n = 1'b1;
    clock_source_select = 1'b1;
    cyc(10);
    chk("clk_oe_n", 16'h0001, {15'h0000, serial_shift_clock_oe_n});
    convert(16'h8001, 1'b0);
    // Two edges flush the link reset, three more carry the toggle across
    u_host.pulses(6);
    cyc(3);
    chk("sdo", 16'h0001, {15'h0000, serial_result_out});
    // Select needs two host edges through the sync, the third shifts
    cs_n = 1'b0;
    u_host.pulses(3);
    cyc(1);
    chk("sdo", 16'h0000, {15'h0000, serial_result_out});
    u_host.pulses(14);
    cyc(1);
    chk("sdo", 16'h0001, {15'h0000, serial_result_out});
    stop_test();
  end
endmodule // tb_top
